// ==== adc_host_model.sv ====
// host model: frames, serial clock, channel select
`timescale 1ns/1ns
module adc_host_model (
	output reg  CS_N,
	output reg  SCLK,
	output reg  SDI,
	input  wire SDO
);
	initial begin
		CS_N = 1'b1;
		SCLK = 1'b1;
		SDI = 1'b0;
	end
	task frame(input ch, input [4:0] n, output [15:0] w);
		integer k;
		begin
			w = 16'h0000;
			// keep pin edges off the system clock's sampling edge
			#10;
			CS_N = 1'b0;
			#400;
			for (k = 0; k < n; k = k + 1) begin
				SDI = (k == 2) ? ch : ~ch;
				#100 if (k > 0) w[16 - k] = SDO;
				SCLK = 1'b0;
				#200 SCLK = 1'b1;
				#100;
			end
			#100 w[16 - n] = SDO;
			CS_N = 1'b1;
			SDI = ~SDI;
			#390;
		end
	endtask
endmodule // adc_host_model

// ==== adc_port_defines.vh ====
// constants for the two-channel converter serial port
`ifndef ADC_PORT_DEFINES_VH
`define ADC_PORT_DEFINES_VH
`define WORD_BITS        16
`define CNT_W            5
`define RES12_BITS       12
`define RES10_BITS       10
`define HDR_BITS         4
`define CHSEL_POS        13
`define WORD_LAST        5'h10
`define CNT_ZERO         5'h00
`define CNT_ONE          5'h01
`define MODE_NORMAL      1'b0
`define FIFO_DEPTH       16
`define FIFO_AW          4
`define ST_IDLE          2'h0
`define ST_CONV          2'h1
`define ST_DONE          2'h2
`endif

// ==== adc_port_properties.sv ====
// pin-level assertions for the serial port
`timescale 1ns/1ns
module adc_port_properties (
	input wire CLK_SYS,
	input wire RESET,
	input wire CS_N,
	input wire SCLK,
	input wire SDO,
	input wire CHAN_SEL,
	input wire TRACK,
	input wire CONV_STROBE
);
	reg [4:0] n_q;
	always @(posedge CLK_SYS or posedge RESET)
		if (RESET || CS_N)
			n_q <= 5'h00;
		else if ($fell(SCLK))
			n_q <= n_q + 5'h01;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	a_strobe_start: assert property ($fell(CS_N) |-> ##[2:5] CONV_STROBE)
		else $error("no strobe");
	a_strobe_hold: assert property (CONV_STROBE |-> !TRACK ##1 !CONV_STROBE)
		else $error("bad strobe");
	a_abort_track: assert property ($rose(CS_N) |-> ##[1:5] TRACK)
		else $error("no track");
	a_sdo_fall: assert property ($changed(SDO) |-> !SCLK || CS_N)
		else $error("sdo off edge");
	a_chan_fall: assert property ($changed(CHAN_SEL) |-> !SCLK && !CS_N)
		else $error("chan off edge");
	a_lead_zero: assert property ($fell(SCLK) && n_q == 5'h02 |-> !SDO)
		else $error("lead bit");
	a_mode_bit: assert property ($fell(SCLK) && n_q == 5'h04 |-> !SDO)
		else $error("mode bit");
	a_track_low: assert property (n_q == 5'h0f |-> !TRACK)
		else $error("early track");
	a_track_end: assert property ($fell(SCLK) && n_q == 5'h0f |-> ##[2:6] TRACK)
		else $error("late track");
endmodule // adc_port_properties
bind adc_serial_port adc_port_properties prop_i (.CLK_SYS(CLK_SYS), .RESET(RESET),
	.CS_N(CS_N), .SCLK(SCLK), .SDO(SDO), .CHAN_SEL(CHAN_SEL), .TRACK(TRACK),
	.CONV_STROBE(CONV_STROBE));

// ==== adc_serial_port.v ====
// serial port and conversion control of a two-channel converter
// Functional notes
// - output bits shift on serial clock falling edge
// - twelve-bit word: 00, channel, mode, result
// - ten-bit word: header, result, two zeros
// - low chip select starts and frames conversion
// - serial clock alone paces the conversion
// - input line captured on falling clock edges
// - third msb of input selects channel
// - track-and-hold returns to track at end
// - fourth msb reports the mode, always normal (0)
// - results are straight unsigned binary codes
// - one sixteen-bit word per frame
`timescale 1ns/1ns
`include "adc_port_defines.vh"
module adc_serial_port #(
	parameter RES_BITS = `RES12_BITS
) (
	input  wire                CLK_SYS,
	input  wire                RESET,
	input  wire                CS_N,
	input  wire                SCLK,
	input  wire                SDI,
	output reg                 SDO,
	input  wire [RES_BITS-1:0] RESULT_DATA,
	input  wire                RESULT_VALID,
	output reg                 RESULT_READY,
	output reg                 CHAN_SEL,
	output reg                 TRACK,
	output reg                 CONV_STROBE
);
	localparam PAD_BITS = `WORD_BITS - `HDR_BITS - RES_BITS;
	localparam FW       = RES_BITS + 1;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	reg  [1:0] cs_sync_q;
	reg  [1:0] sclk_sync_q;
	reg  [1:0] sdi_sync_q;
	reg        sclk_prev_q;
	reg        cs_prev_q;
	wire       cs_n_s;
	wire       sclk_fall;
	wire       frame_start;
	assign cs_n_s      = cs_sync_q[1];
	assign sclk_fall   = sclk_prev_q & ~sclk_sync_q[1];
	assign frame_start = cs_prev_q & ~cs_n_s;
	always @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			cs_sync_q   <= 2'h3;
			sclk_sync_q <= 2'h3;
			sdi_sync_q  <= 2'h0;
			sclk_prev_q <= 1'b1;
			cs_prev_q   <= 1'b1;
		end else begin
			cs_sync_q   <= {cs_sync_q[0], CS_N};
			sclk_sync_q <= {sclk_sync_q[0], SCLK};
			sdi_sync_q  <= {sdi_sync_q[0], SDI};
			sclk_prev_q <= sclk_sync_q[1];
			cs_prev_q   <= cs_n_s;
		end
	end

	// ------------------------------------------------------------
	// result buffer between converter core and shifter
	// ------------------------------------------------------------
	wire [FW-1:0] fifo_out;
	wire          fifo_valid;
	wire          fifo_in_ready;
	reg           fifo_pop;
	reg           chan_q;
	result_fifo #(
		.WIDTH (FW),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_fifo (
		.clk       (CLK_SYS),
		.rst       (RESET),
		.in_data   ({chan_q, RESULT_DATA}),
		.in_valid  (RESULT_VALID),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	// ------------------------------------------------------------
	// frame control
	// ------------------------------------------------------------
	reg [1:0]            state_q;
	reg [`CNT_W-1:0]     cnt_q;
	reg [`WORD_BITS-1:0] shift_q;
	reg [`WORD_BITS-1:0] din_q;
	wire                 word_done;
	assign word_done = sclk_fall && (cnt_q == `WORD_LAST - `CNT_ONE);

	always @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			state_q      <= `ST_IDLE;
			cnt_q        <= `CNT_ZERO;
			shift_q      <= {`WORD_BITS{1'b0}};
			din_q        <= {`WORD_BITS{1'b0}};
			SDO          <= 1'b0;
			CHAN_SEL     <= 1'b0;
			chan_q       <= 1'b0;
			TRACK        <= 1'b1;
			CONV_STROBE  <= 1'b0;
			RESULT_READY <= 1'b0;
			fifo_pop     <= 1'b0;
		end else begin
			CONV_STROBE  <= 1'b0;
			fifo_pop     <= 1'b0;
			RESULT_READY <= fifo_in_ready;
			if (cs_n_s && state_q != `ST_IDLE) begin
				state_q <= `ST_IDLE;
				TRACK   <= 1'b1;
				SDO     <= 1'b0;
			end else begin
				case (state_q)
				`ST_IDLE: begin
					if (frame_start) begin
						state_q     <= `ST_CONV;
						TRACK       <= 1'b0;
						CONV_STROBE <= 1'b1;
						cnt_q       <= `CNT_ZERO;
						SDO         <= 1'b0;
						// header and result fixed at frame start, msb first
						if (fifo_valid) begin
							fifo_pop <= 1'b1;
							shift_q  <= {2'b00, fifo_out[FW-1], `MODE_NORMAL,
								fifo_out[RES_BITS-1:0], {PAD_BITS{1'b0}}};
						end else begin
							shift_q  <= {2'b00, chan_q, `MODE_NORMAL,
								{RES_BITS{1'b0}}, {PAD_BITS{1'b0}}};
						end
					end
				end
				`ST_CONV: begin
					if (sclk_fall) begin
						SDO     <= shift_q[`WORD_BITS-1];
						shift_q <= {shift_q[`WORD_BITS-2:0], 1'b0};
						din_q   <= {din_q[`WORD_BITS-2:0], sdi_sync_q[1]};
						cnt_q   <= cnt_q + `CNT_ONE;
						if (cnt_q == `WORD_BITS - 1 - `CHSEL_POS) begin
							CHAN_SEL <= sdi_sync_q[1];
							chan_q   <= sdi_sync_q[1];
						end
					end
					if (word_done) begin
						state_q <= `ST_DONE;
						TRACK   <= 1'b1;
					end
				end
				`ST_DONE: begin
					// extra clocks in the frame shift out zeros
					if (sclk_fall)
						SDO <= 1'b0;
				end
				default: begin
					state_q <= `ST_IDLE;
				end
				endcase
			end
		end
	end
endmodule // adc_serial_port

// ==== adc_serial_port_tb_top.sv ====
// self-checking bench for the serial port
`timescale 1ns/1ns
module adc_serial_port_tb_top;
	reg         CLK_SYS;
	reg         RESET;
	reg  [11:0] RESULT_DATA;
	reg         RESULT_VALID;
	wire        CS_N, SCLK, SDI, SDO, RESULT_READY, CHAN_SEL, TRACK, CONV_STROBE;
	wire        SDO10;
	integer     err_count, total_checks, i, p;
	integer     strobe_n;
	reg  [15:0] w;
	reg  [15:0] w10;
	reg  [12:0] rows [0:3];
	adc_serial_port dut (.CLK_SYS(CLK_SYS), .RESET(RESET), .CS_N(CS_N), .SCLK(SCLK),
		.SDI(SDI), .SDO(SDO), .RESULT_DATA(RESULT_DATA), .RESULT_VALID(RESULT_VALID),
		.RESULT_READY(RESULT_READY), .CHAN_SEL(CHAN_SEL), .TRACK(TRACK),
		.CONV_STROBE(CONV_STROBE));
	adc_serial_port #(.RES_BITS(10)) dut10 (.CLK_SYS(CLK_SYS), .RESET(RESET), .CS_N(CS_N),
		.SCLK(SCLK), .SDI(SDI), .SDO(SDO10), .RESULT_DATA(RESULT_DATA[11:2]),
		.RESULT_VALID(RESULT_VALID), .RESULT_READY(), .CHAN_SEL(), .TRACK(),
		.CONV_STROBE());
	adc_host_model host (.CS_N(CS_N), .SCLK(SCLK), .SDI(SDI), .SDO(SDO));
	// ten-bit word captured on serial clock rises, where it stands settled
	always @(posedge SCLK)
		if (CS_N === 1'b0)
			w10 <= {w10[14:0], SDO10};
	always @(posedge CLK_SYS)
		if (CONV_STROBE === 1'b1)
			strobe_n <= strobe_n + 1;
	task chk(input [39:0] nm, input [15:0] e, input [15:0] s);
		begin
			total_checks = total_checks + 1;
			if (e !== s) begin
				err_count = err_count + 1;
				$display("mismatch %0s exp %h got %h", nm, e, s);
			end
		end
	endtask
	task push(input [11:0] d);
		begin
			@(posedge CLK_SYS);
			RESULT_DATA <= d;
			RESULT_VALID <= 1'b1;
			@(posedge CLK_SYS);
			RESULT_VALID <= 1'b0;
			repeat (2) @(posedge CLK_SYS);
		end
	endtask
	task give_verdict;
		begin
			if (err_count == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	initial begin
		CLK_SYS = 1'b0;
		forever #25 CLK_SYS = ~CLK_SYS;
	end
	initial begin
		#1000000 err_count = err_count + 1;
		give_verdict;
	end
	initial begin
		err_count = 0;
		total_checks = 0;
		strobe_n = 0;
		w10 = 16'h0000;
		RESET = 1'b1;
		RESULT_DATA = 12'h000;
		RESULT_VALID = 1'b0;
		rows[0] = 13'h1fff;
		rows[1] = 13'h0000;
		rows[2] = 13'h1a5c;
		rows[3] = 13'h05a3;
		repeat (8) @(posedge CLK_SYS);
		chk("rst", 16'h0004, {12'h000, SDO, TRACK, CHAN_SEL, CONV_STROBE});
		RESET <= 1'b0;
		repeat (4) @(posedge CLK_SYS);
		host.frame(1'b1, 5'h05, w);
		chk("abort", 16'h0001, {15'h0000, TRACK});
		for (i = 0; i < 5; i = i + 1) begin
			host.frame(rows[i % 4][12], 5'h10, w);
			if (i > 0) chk("word", {2'b00, rows[i - 1][12], 1'b0, rows[i - 1][11:0]}, w);
			if (i > 0) chk("wrd10", {2'b00, rows[i - 1][12], 1'b0, rows[i - 1][11:2], 2'b00}, w10);
			chk("chtrk", {14'h0000, rows[i % 4][12], 1'b1}, {14'h0000, CHAN_SEL, TRACK});
			push(rows[i % 4][11:0]);
		end
		for (p = 0; p < 20 && RESULT_READY === 1'b1; p = p + 1)
			push({p[3:0], 4'ha, p[3:0]});
		chk("fill", 16'h000f, p[15:0]);
		for (i = 0; i < 17; i = i + 1) begin
			host.frame(1'b0, 5'h10, w);
			if (i == 16) chk("empty", 16'h0000, {4'h0, w[11:0]});
			else chk("drain", i ? {4'h2, i[3:0] - 4'h1, 4'ha, i[3:0] - 4'h1} : 16'h2fff, w);
		end
		// reset in mid-run, then one frame from an empty buffer
		RESET <= 1'b1;
		repeat (2) @(posedge CLK_SYS);
		chk("rst2", 16'h0004, {12'h000, SDO, TRACK, CHAN_SEL, CONV_STROBE});
		RESET <= 1'b0;
		repeat (4) @(posedge CLK_SYS);
		host.frame(1'b1, 5'h10, w);
		chk("rword", 16'h0000, w);
		chk("rchan", 16'h0001, {15'h0000, CHAN_SEL});
		chk("strob", 16'd24, strobe_n[15:0]);
		give_verdict;
	end
endmodule // adc_serial_port_tb_top

// ==== result_fifo.v ====
// parameterised valid/ready fifo for conversion results
`timescale 1ns/1ns
`include "adc_port_defines.vh"
module result_fifo #(
	parameter WIDTH = 13,
	parameter DEPTH = `FIFO_DEPTH,
	parameter AW    = `FIFO_AW
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_q;
	reg [AW:0]      rd_q;
	wire            full;
	wire            empty;
	assign empty     = (wr_q == rd_q);
	assign full      = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem[rd_q[AW-1:0]];
	always @(posedge clk) begin
		if (in_valid && !full)
			mem[wr_q[AW-1:0]] <= in_data;
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full)
				wr_q <= wr_q + 1'b1;
			if (out_ready && !empty)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule // result_fifo
